// ---- hdl/intc_pkg.sv ----
// Constants, types and states shared by the interrupt controller.
// Assumes a byte-wide CPU memory port and a 32-bit Avalon-MM slave.
package intc_pkg;

  // ----------------------------------------------------------------
  // Vector table
  // ----------------------------------------------------------------
  localparam int          NUM_VEC       = 32;
  localparam logic [15:0] VEC_TOP       = 16'hFFFE;
  localparam logic [4:0]  VEC_RESET     = 5'h00;
  localparam logic [4:0]  VEC_SWI       = 5'h01;
  localparam logic [4:0]  VEC_EXT       = 5'h02;
  // Vectors 3..29 carry peripherals; 8, 13 and 14 are reserved
  localparam logic [31:0] VEC_USED_MASK = 32'h3FFF9EF8;
  localparam logic [2:0]  PUSH_LAST     = 3'h4;
  localparam logic [2:0]  FILL_LAST     = 3'h2;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_EXT_CTRL = 4'h0;
  localparam logic [3:0] REG_GMASK    = 4'h4;
  localparam logic [3:0] REG_STATUS   = 4'h8;
  localparam int         F_PIN_EN     = 0;
  localparam int         F_POL        = 1;
  localparam int         F_LEVEL      = 2;
  localparam int         F_PULL_DIS   = 3;
  localparam int         F_INT_EN     = 4;
  localparam int         F_FLAG       = 5;
  localparam int         F_ACK        = 6;
  localparam logic [4:0] EXT_CFG_RST  = 5'h00;
  localparam logic       GMASK_RST    = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0]  x;
    logic [7:0]  a;
    logic [7:0]  condition_code_reg;
  } cpu_ctx_t;

  typedef struct packed {
    logic int_en;
    logic pull_dis;
    logic level;
    logic pol;
    logic pin_en;
  } ext_cfg_t;

  typedef enum logic [2:0] {
    S_RST_HI, S_RST_LO, S_IDLE, S_PUSH, S_VEC_HI, S_VEC_LO, S_FILL, S_POP
  } seq_state_t;

endpackage : intc_pkg

// ---- hdl/ext_pin_detect.sv ----
// External interrupt pin: synchroniser, edge/level flag, pulls, wake.
// Assumes the pin is asynchronous to clk; rst_n is already synchronised.
`timescale 1ns/1ps
module ext_pin_detect
  import intc_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst_n,
  input  wire logic     pin_raw,
  input  wire ext_cfg_t cfg,
  input  wire logic     flag_clr,
  input  wire logic     stop_mode,
  output logic          flag,
  output logic          request,
  output logic          wake,
  output logic          pull_up_en,
  output logic          pull_dn_en
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic flag_reg;
  logic flag_next;
  logic asserted;
  logic set_evt;

  // ----------------------------------------------------------------
  // Synchroniser and detection
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // Disabled pin never counts as asserted
  assign asserted = cfg.pin_en & (sync2_reg ~^ cfg.pol);
  assign set_evt  = asserted & ~prev_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) prev_reg <= 1'b0;
    else        prev_reg <= asserted;
  end

  // Set beats clear; level mode holds the flag while asserted
  always_comb begin
    flag_next = set_evt | (flag_reg & ~flag_clr);
    if (cfg.level && asserted && flag_reg) flag_next = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) flag_reg <= 1'b0;
    else        flag_reg <= flag_next;
  end

  assign flag       = flag_reg;
  assign request    = flag_reg & cfg.int_en;
  // Unclocked path, usable with clocks stopped
  assign wake       = stop_mode & cfg.pin_en & (pin_raw ~^ cfg.pol);
  assign pull_up_en = cfg.pin_en & ~cfg.pull_dis & ~cfg.pol;
  assign pull_dn_en = cfg.pin_en & ~cfg.pull_dis & cfg.pol;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_level_hold: assert property (
    cfg.level && flag_reg && asserted && $stable(cfg) |=> flag_reg)
    else $error("level flag dropped while pin asserted");
  chk_edge_clear: assert property (
    !cfg.level && flag_clr && !set_evt |=> !flag_reg)
    else $error("edge flag not cleared");
  chk_pin_ignore: assert property (
    !cfg.pin_en && !flag_reg ##1 !cfg.pin_en |-> !flag_reg)
    else $error("disabled pin set the flag");

endmodule : ext_pin_detect

// ---- hdl/vector_select.sv ----
// Per-vector request gating and fixed-priority vector choice.
// Assumes flag and enable inputs are on clk; SRC_PER_VEC bits per vector.
`timescale 1ns/1ps
module vector_select
  import intc_pkg::*;
#(
  parameter int SRC_PER_VEC = 8
) (
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  input  wire logic [NUM_VEC*SRC_PER_VEC-1:0] src_flag,
  input  wire logic [NUM_VEC*SRC_PER_VEC-1:0] src_enable,
  input  wire logic                           ext_req,
  output logic                                found,
  output logic [4:0]                          vec
);

  logic [NUM_VEC-1:0] req;
  logic               any;
  logic [4:0]         pick;

  generate
    if (SRC_PER_VEC < 1) begin : g_bad
      $error("SRC_PER_VEC must be at least 1");
    end
    for (genvar v = 0; v < NUM_VEC; v++) begin : g_vec
      if (v == VEC_EXT) begin : g_ext
        assign req[v] = ext_req;
      end else begin : g_src
        // OR of locally enabled flags sharing this vector
        assign req[v] = VEC_USED_MASK[v] &
          |(src_flag[v*SRC_PER_VEC +: SRC_PER_VEC] & src_enable[v*SRC_PER_VEC +: SRC_PER_VEC]);
      end
    end
  endgenerate

  // Lowest vector number wins
  always_comb begin
    any  = 1'b0;
    pick = 5'h00;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (req[i]) begin
        any  = 1'b1;
        pick = 5'(i);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      found <= 1'b0;
      vec   <= 5'h00;
    end else begin
      found <= any;
      vec   <= pick;
    end
  end

endmodule : vector_select

// ---- hdl/intc_top.sv ----
// Interrupt controller: external pin, vector choice, stack sequencer.
// Assumes a byte memory that holds mem_ack high for one cycle per access.
//
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module intc_top
  import intc_pkg::*;
#(
  parameter int SRC_PER_VEC = 8,
  parameter int I_BIT_POS   = 3
) (
  input  wire logic                           clk,
  input  wire logic                           arst_n,
  input  wire logic [3:0]                     avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [31:0]                    avs_writedata,
  output logic      [31:0]                    avs_readdata,
  output logic                                avs_waitrequest,
  input  wire logic                           irq_pin,
  input  wire logic                           stop_mode,
  output logic                                wake_req,
  output logic                                pull_up_en,
  output logic                                pull_dn_en,
  input  wire logic [NUM_VEC*SRC_PER_VEC-1:0] src_flag,
  input  wire logic [NUM_VEC*SRC_PER_VEC-1:0] src_enable,
  input  wire cpu_ctx_t                       cpu_ctx_in,
  input  wire logic                           insn_done,
  input  wire logic                           swi_exec,
  input  wire logic                           rti_exec,
  output logic                                mem_req,
  output logic                                mem_we,
  output logic      [15:0]                    mem_addr,
  output logic      [7:0]                     mem_wdata,
  input  wire logic [7:0]                     mem_rdata,
  input  wire logic                           mem_ack,
  output cpu_ctx_t                            ctx_out,
  output logic                                ctx_load,
  output logic      [7:0]                     queue_byte,
  output logic                                queue_valid,
  output logic                                seq_busy,
  output logic                                global_mask
);

  generate
    if (I_BIT_POS < 0 || I_BIT_POS > 7) begin : g_bad
      $error("I_BIT_POS must select a bit of the CONDITION_CODE_REG");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_s1_reg;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ext_cfg_t   cfg_reg;
  logic       i_mask_reg;
  logic       ack_reg;
  logic       wr_en;
  logic       flag_clr;
  logic       ext_flag;
  logic       ext_req;
  logic       irq_found;
  logic [4:0] irq_vec;
  seq_state_t state_reg;
  logic [2:0] cnt_reg;
  cpu_ctx_t   work_reg;
  logic [4:0] vec_reg;
  logic [15:0] sp_entry_reg;
  logic       take_irq;
  logic       take_swi;
  logic       take_rti;
  logic       push_done;
  logic [15:0] vec_addr;

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // One wait state: request seen, then answered
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_en           = avs_write & ack_reg;
  assign flag_clr        = wr_en & (avs_address == REG_EXT_CTRL) & avs_writedata[F_ACK];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ack_reg <= 1'b0;
    else        ack_reg <= (avs_read | avs_write) & ~ack_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= EXT_CFG_RST;
    end else if (wr_en && avs_address == REG_EXT_CTRL) begin
      cfg_reg <= avs_writedata[F_INT_EN:F_PIN_EN];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      case (avs_address)
        REG_EXT_CTRL: avs_readdata <= {26'h0, ext_flag, cfg_reg};
        REG_GMASK:    avs_readdata <= {31'h0, i_mask_reg};
        REG_STATUS:   avs_readdata <= {15'h0, irq_found, 3'h0, vec_reg, 7'h0, seq_busy};
        default:      avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // External pin and source gating
  // ----------------------------------------------------------------
  ext_pin_detect u_ext (
    .clk        (clk),
    .rst_n      (rst_n),
    .pin_raw    (irq_pin),
    .cfg        (cfg_reg),
    .flag_clr   (flag_clr),
    .stop_mode  (stop_mode),
    .flag       (ext_flag),
    .request    (ext_req),
    .wake       (wake_req),
    .pull_up_en (pull_up_en),
    .pull_dn_en (pull_dn_en)
  );

  vector_select #(
    .SRC_PER_VEC (SRC_PER_VEC)
  ) u_sel (
    .clk        (clk),
    .rst_n      (rst_n),
    .src_flag   (src_flag),
    .src_enable (src_enable),
    .ext_req    (ext_req),
    .found      (irq_found),
    .vec        (irq_vec)
  );

  // ----------------------------------------------------------------
  // Global mask
  // ----------------------------------------------------------------
  assign push_done = (state_reg == S_PUSH) && (cnt_reg == PUSH_LAST) && mem_ack;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      i_mask_reg <= GMASK_RST;
    end else if (push_done) begin
      i_mask_reg <= 1'b1;
    end else if (state_reg == S_POP && cnt_reg == 3'h0 && mem_ack) begin
      i_mask_reg <= mem_rdata[I_BIT_POS];
    end else if (wr_en && avs_address == REG_GMASK) begin
      i_mask_reg <= avs_writedata[0];
    end
  end

  assign global_mask = i_mask_reg;

  // ----------------------------------------------------------------
  // Stacking sequencer
  // ----------------------------------------------------------------
  // Instruction boundary gates every entry
  assign take_rti = insn_done & rti_exec;
  assign take_swi = insn_done & swi_exec & ~rti_exec;
  assign take_irq = insn_done & ~rti_exec & ~swi_exec & irq_found & ~i_mask_reg;
  assign vec_addr = VEC_TOP - {10'h000, vec_reg, 1'b0};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_RST_HI;
      cnt_reg   <= 3'h0;
      vec_reg   <= VEC_RESET;
    end else begin
      case (state_reg)
        S_RST_HI: if (mem_ack) state_reg <= S_RST_LO;
        S_RST_LO: if (mem_ack) begin
          state_reg <= S_FILL;
          cnt_reg   <= 3'h0;
        end
        S_IDLE: begin
          cnt_reg <= 3'h0;
          if (take_rti) begin
            state_reg <= S_POP;
          end else if (take_swi) begin
            state_reg <= S_PUSH;
            vec_reg   <= VEC_SWI;
          end else if (take_irq) begin
            state_reg <= S_PUSH;
            vec_reg   <= irq_vec;
          end
        end
        S_PUSH: if (mem_ack) begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == PUSH_LAST) begin
            state_reg <= S_VEC_HI;
            cnt_reg   <= 3'h0;
          end
        end
        S_VEC_HI: if (mem_ack) state_reg <= S_VEC_LO;
        S_VEC_LO: if (mem_ack) begin
          state_reg <= S_FILL;
          cnt_reg   <= 3'h0;
        end
        S_FILL: if (mem_ack) begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == FILL_LAST) begin
            state_reg <= S_IDLE;
            cnt_reg   <= 3'h0;
          end
        end
        S_POP: if (mem_ack) begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == PUSH_LAST) begin
            state_reg <= S_FILL;
            cnt_reg   <= 3'h0;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Context under construction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      work_reg     <= '0;
      sp_entry_reg <= 16'h0000;
    end else begin
      case (state_reg)
        S_IDLE: if (take_rti || take_swi || take_irq) begin
          work_reg     <= cpu_ctx_in;
          sp_entry_reg <= cpu_ctx_in.sp;
        end
        S_RST_HI: if (mem_ack) work_reg.pc[15:8] <= mem_rdata;
        S_RST_LO: if (mem_ack) work_reg.pc[7:0]  <= mem_rdata;
        S_PUSH: if (mem_ack) begin
          work_reg.sp <= work_reg.sp - 16'h0001;
          if (cnt_reg == PUSH_LAST) work_reg.condition_code_reg[I_BIT_POS] <= 1'b1;
        end
        S_VEC_HI: if (mem_ack) work_reg.pc[15:8] <= mem_rdata;
        S_VEC_LO: if (mem_ack) work_reg.pc[7:0]  <= mem_rdata;
        S_POP: if (mem_ack) begin
          work_reg.sp <= work_reg.sp + 16'h0001;
          case (cnt_reg)
            3'h0:    work_reg.condition_code_reg       <= mem_rdata;
            3'h1:    work_reg.a         <= mem_rdata;
            3'h2:    work_reg.x         <= mem_rdata;
            3'h3:    work_reg.pc[15:8]  <= mem_rdata;
            default: work_reg.pc[7:0]   <= mem_rdata;
          endcase
        end
        default: work_reg <= work_reg;
      endcase
    end
  end

  // Memory request, held until acknowledged
  always_comb begin
    mem_req   = 1'b1;
    mem_we    = 1'b0;
    mem_addr  = 16'h0000;
    mem_wdata = 8'h00;
    case (state_reg)
      S_RST_HI: mem_addr = VEC_TOP;
      S_RST_LO: mem_addr = VEC_TOP + 16'h0001;
      S_PUSH: begin
        mem_we   = 1'b1;
        mem_addr = work_reg.sp;
        case (cnt_reg)
          3'h0:    mem_wdata = work_reg.pc[7:0];
          3'h1:    mem_wdata = work_reg.pc[15:8];
          3'h2:    mem_wdata = work_reg.x;
          3'h3:    mem_wdata = work_reg.a;
          default: mem_wdata = work_reg.condition_code_reg;
        endcase
      end
      S_VEC_HI: mem_addr = vec_addr;
      S_VEC_LO: mem_addr = vec_addr + 16'h0001;
      S_FILL:   mem_addr = work_reg.pc + {13'h0000, cnt_reg};
      S_POP:    mem_addr = work_reg.sp + 16'h0001;
      default:  mem_req  = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // CPU outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      queue_byte  <= 8'h00;
      queue_valid <= 1'b0;
      ctx_load    <= 1'b0;
      ctx_out     <= '0;
    end else begin
      queue_valid <= (state_reg == S_FILL) && mem_ack;
      if (state_reg == S_FILL && mem_ack) queue_byte <= mem_rdata;
      ctx_load <= (state_reg == S_FILL) && mem_ack && (cnt_reg == FILL_LAST);
      if (state_reg == S_FILL && mem_ack && cnt_reg == FILL_LAST) ctx_out <= work_reg;
    end
  end

  assign seq_busy = (state_reg != S_IDLE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_push_end;
    (state_reg == S_PUSH) && (cnt_reg == PUSH_LAST) && mem_ack;
  endsequence
  sequence seq_vec_end;
    (state_reg == S_VEC_LO) && mem_ack;
  endsequence
  sequence seq_fill_end;
    (state_reg == S_FILL) && (cnt_reg == FILL_LAST) && mem_ack;
  endsequence

  chk_push_first: assert property (
    state_reg == S_PUSH && cnt_reg == 3'h0 |->
      mem_we && mem_addr == sp_entry_reg && mem_wdata == work_reg.pc[7:0])
    else $error("first push not PC low at entry SP");
  chk_sp_frame: assert property (
    seq_push_end |=> work_reg.sp == sp_entry_reg - 16'h0005 && i_mask_reg)
    else $error("SP or mask wrong after stacking");
  chk_vec_order: assert property (
    seq_push_end |=> state_reg == S_VEC_HI && mem_addr == vec_addr && !mem_we)
    else $error("vector high byte not fetched first");
  chk_vec_fill: assert property (
    seq_vec_end |=> state_reg == S_FILL && cnt_reg == 3'h0 && mem_addr == work_reg.pc)
    else $error("fill does not start at vector target");
  chk_fill_done: assert property (
    seq_fill_end |=> state_reg == S_IDLE && ctx_load && queue_valid)
    else $error("fill did not end after three bytes");
  chk_pop_first: assert property (
    state_reg == S_POP && cnt_reg == 3'h0 |-> !mem_we && mem_addr == sp_entry_reg + 16'h0001)
    else $error("pop does not start above SP");
  chk_masked_wait: assert property (
    state_reg == S_IDLE && insn_done && i_mask_reg && !swi_exec && !rti_exec |=>
      state_reg == S_IDLE)
    else $error("masked request taken");
  chk_reset_fetch: assert property (
    state_reg == S_RST_HI |-> mem_req && mem_addr == VEC_TOP && i_mask_reg)
    else $error("reset vector fetch wrong");
  chk_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

endmodule : intc_top

// ---- test/intc_mem_model.sv ----
// Byte memory on the CPU side: holds stack and vector table.
// Assumes one access held until its one-cycle ack; lat adds wait.
`timescale 1ns/1ps
module intc_mem_model (
  input  wire logic        clk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic [1:0]  lat,
  output logic             mem_ack,
  output logic      [7:0]  mem_rdata
);
  // ----------------------------------------------------------------
  // Storage and answer
  // ----------------------------------------------------------------
  logic [7:0] mem [0:65535];
  logic [1:0] wait_reg;
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'(i ^ (i >> 8));
    mem_ack = 1'b0;
    mem_rdata = 8'hA5;
    wait_reg = 2'h0;
  end
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;  // No stale byte outside an ack
    if (mem_req && !mem_ack && wait_reg != 2'h0) wait_reg <= wait_reg - 2'h1;
    else if (mem_req && !mem_ack) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr];
      if (mem_we) mem[mem_addr] <= mem_wdata;
      wait_reg <= lat;
    end
  end
endmodule : intc_mem_model

// ---- test/interrupt_vectoring_ext_pin_tb.sv ----
// Bench for the interrupt controller; the bench plays the CPU core.
// Assumes intc_mem_model as the byte memory behind the stack port.
`timescale 1ns/1ps
module interrupt_vectoring_ext_pin_tb import intc_pkg::*; ;
  // ----------------------------------------------------------------
  // Signals, design and memory
  // ----------------------------------------------------------------
  logic clk, arst_n, avs_read, avs_write, irq_pin, stop_mode, insn_done, swi_exec, rti_exec;
  logic avs_waitrequest, wake_req, pull_up_en, pull_dn_en, mem_req, mem_we, mem_ack;
  logic ctx_load, queue_valid, seq_busy, global_mask;
  logic [3:0]           avs_address;
  logic [31:0]          avs_writedata, avs_readdata, rd;
  logic [15:0]          mem_addr;
  logic [7:0]           mem_wdata, mem_rdata, queue_byte, q_first;
  logic [NUM_VEC*8-1:0] src_flag, src_enable;
  logic [1:0]           lat;
  cpu_ctx_t             cpu_ctx_in, ctx_out, c;
  int                   error_cnt, checked, q_cnt, v1, v2;
  intc_top #(.SRC_PER_VEC(8), .I_BIT_POS(3)) dut (.clk, .arst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq_pin, .stop_mode,
    .wake_req, .pull_up_en, .pull_dn_en, .src_flag, .src_enable, .cpu_ctx_in, .insn_done,
    .swi_exec, .rti_exec, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
    .ctx_out, .ctx_load, .queue_byte, .queue_valid, .seq_busy, .global_mask);
  intc_mem_model ram (.clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .lat, .mem_ack,
    .mem_rdata);
  always #5 clk = ~clk;
  always @(posedge clk) if (insn_done === 1'b1) q_cnt <= 0;
  else if (queue_valid === 1'b1) begin
    if (q_cnt == 0) q_first <= queue_byte;
    q_cnt <= q_cnt + 1;
  end
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction : pat
  function automatic logic [15:0] vpc(input int v);
    logic [15:0] a;
    a = 16'hFFFE - 16'(2 * v);
    return {pat(a), pat(a + 16'h1)};
  endfunction : vpc
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
    int n = 0;
    avs_address <= ad;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin @(posedge clk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin error_cnt++; test_done(); end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic go(input logic return_from_interrupt);
    int n = 0;
    rti_exec <= return_from_interrupt;
    insn_done <= 1'b1;
    @(posedge clk);
    rti_exec <= 1'b0;
    insn_done <= 1'b0;
    do begin @(negedge clk); n++; end while (ctx_load !== 1'b1 && n < 500);
    if (n >= 500) begin error_cnt++; test_done(); end
  endtask : go
  task automatic fill_chk(input logic [15:0] pc);
    repeat (2) @(negedge clk);
    chk("fill", {8'h3, pat(pc)}, {q_cnt[7:0], q_first});
    @(posedge clk);
  endtask : fill_chk
  task automatic pin_edge();
    irq_pin <= 1'b0;
    repeat (6) @(posedge clk);
    irq_pin <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : pin_edge
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {clk, arst_n, avs_read, avs_write, irq_pin, stop_mode, insn_done, swi_exec, rti_exec} = '0;
    {avs_address, avs_writedata, src_flag, src_enable, lat, cpu_ctx_in} = '0;
    {error_cnt, checked} = '0;
    void'($urandom(32'hB2A0));
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    go(1'b0);
    chk("reset pc", vpc(0), ctx_out.pc);
    chk("reset mask", 32'h1, global_mask);
    fill_chk(vpc(0));
    $display("test reset done");
    for (int r = 0; r < 4; r++) begin
      lat <= 2'($urandom_range(0, 2));
      bus(1'b1, REG_GMASK, 32'h0);
      do v1 = $urandom_range(3, 29); while (!VEC_USED_MASK[v1]);
      do v2 = $urandom_range(3, 29); while (!VEC_USED_MASK[v2]);
      // Stack kept clear of every fill target
      c = {1'b1, 15'($urandom), 16'($urandom_range(16'h0400, 16'h06F0)), 24'($urandom)};
      c.condition_code_reg[3] = 1'b0;
      src_flag <= '1;
      src_enable <= ({255'h0, 1'b1} << (v1 * 8 + $urandom_range(0, 7)))
                  | ({255'h0, 1'b1} << (v2 * 8 + $urandom_range(0, 7)));
      cpu_ctx_in <= c;
      repeat (4) @(posedge clk);
      go(1'b0);
      chk("entry pc", vpc(v1 < v2 ? v1 : v2), ctx_out.pc);
      chk("entry sp", c.sp - 16'h5, ctx_out.sp);
      chk("frame", {c.pc[7:0], c.pc[15:8], c.x, c.a}, {ram.mem[c.sp], ram.mem[c.sp - 16'h1],
        ram.mem[c.sp - 16'h2], ram.mem[c.sp - 16'h3]});
      chk("entry ccr", {c.condition_code_reg, c.condition_code_reg | 8'h8, 8'h1}, {ram.mem[c.sp - 16'h4], ctx_out.condition_code_reg,
        7'h0, global_mask});
      fill_chk(vpc(v1 < v2 ? v1 : v2));
      src_enable <= '0;
      cpu_ctx_in.sp <= c.sp - 16'h5;
      @(posedge clk);
      go(1'b1);
      chk("return ctx", {c.pc, c.a, c.condition_code_reg}, {ctx_out.pc, ctx_out.a, ctx_out.condition_code_reg});
      chk("return mask", 32'h0, global_mask);
      fill_chk(c.pc);
      $display("test round %0d done", r);
    end
    bus(1'b1, REG_GMASK, 32'h1);
    src_enable <= '1;
    repeat (3) @(posedge clk);
    insn_done <= 1'b1;
    @(posedge clk);
    insn_done <= 1'b0;
    repeat (2) @(negedge clk);
    chk("masked", 32'h0, seq_busy);
    @(posedge clk);
    swi_exec <= 1'b1;
    go(1'b0);
    chk("swi pc", vpc(VEC_SWI), ctx_out.pc);
    fill_chk(vpc(VEC_SWI));
    swi_exec <= 1'b0;
    src_enable <= '0;
    $display("test masked done");
    bus(1'b1, REG_EXT_CTRL, 32'h43);
    chk("pulls rising", 32'h1, {pull_up_en, pull_dn_en});
    pin_edge();
    bus(1'b0, REG_EXT_CTRL, 32'h0);
    chk("edge flag", 32'h1, rd[F_FLAG]);
    bus(1'b0, REG_STATUS, 32'h0);
    chk("poll only", 32'h0, rd[16]);
    bus(1'b1, REG_EXT_CTRL, 32'h43);
    bus(1'b0, REG_EXT_CTRL, 32'h0);
    chk("edge clear", 32'h0, rd[F_FLAG]);
    stop_mode <= 1'b1;
    @(negedge clk);
    chk("wake", 32'h1, wake_req);
    @(posedge clk);
    stop_mode <= 1'b0;
    bus(1'b1, REG_EXT_CTRL, 32'h47);
    pin_edge();
    bus(1'b1, REG_EXT_CTRL, 32'h47);
    bus(1'b0, REG_EXT_CTRL, 32'h0);
    chk("level sticky", 32'h1, rd[F_FLAG]);
    bus(1'b1, REG_EXT_CTRL, 32'h41);
    chk("pulls falling", 32'h2, {pull_up_en, pull_dn_en});
    bus(1'b1, REG_EXT_CTRL, 32'h49);
    chk("pulls off", 32'h0, {pull_up_en, pull_dn_en});
    bus(1'b1, REG_EXT_CTRL, 32'h51);
    pin_edge();
    bus(1'b0, REG_STATUS, 32'h0);
    chk("pin request", 32'h1, rd[16]);
    bus(1'b1, REG_EXT_CTRL, 32'h42);
    pin_edge();
    bus(1'b0, REG_EXT_CTRL, 32'h0);
    chk("pin ignored", 32'h0, rd[F_FLAG]);
    bus(1'b0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test pin done");
    test_done();
  end
endmodule : interrupt_vectoring_ext_pin_tb
